/* File: hdl/tbc_fifo_ctrl.sv */
/*
  Transmit FIFO buffer control: control register, pointer management in a
  64-entry memory, transmit buffer loading, limit and trigger events, and
  service request selection. Assumes software writes data over din_wr and
  the channel pulses transmit_buffer_reg_take when it has consumed the transmit buffer.
*/
`default_nettype none

// Functional notes
// - Start pointer is write-only, reads zero
// - Start write at size zero loads pointers
// - Start write at nonzero size is ignored
// - Limit field holds target fill level
// - Mode 0 trigger clears at limit
// - Mode 1 trigger clears at full
// - Trigger enable gates trigger bit events
// - Standard node selects outputs 0 to 5
// - Error node selects outputs 0 to 5
// - Size zero disables FIFO, refuses data
// - Size codes 1 to 6 give 2 to 64 entries; code 7 gives none
// - Low select: event on drop from limit
// - High select: event on rise from limit
// - Standard interrupt enable gates request output
// - Write when full is error; enable gates
// - Reserved control bits read zero
// - Control writes need transmit buffer capability
// - First word bypasses FIFO into buffer
// - Trigger bit holds request output active
module tbc_fifo_ctrl
  import tbc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // Register port
  input  wire logic [TBC_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output var  logic [31:0]           reg_rdata,
  // Channel configuration
  input  wire logic                  tx_buffer_capability,
  // Data input location
  input  wire logic                  din_wr,
  input  wire logic [TBC_DATA_W-1:0] din_data,
  // Transmit buffer
  input  wire logic                  transmit_buffer_reg_take,
  output var  logic                  transmit_buffer_reg_valid,
  output var  logic [TBC_DATA_W-1:0] transmit_buffer_reg_data,
  // Service request outputs
  output var  logic [TBC_NODES-1:0]  sr_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Entry count for a size code; zero when disabled
  function automatic logic [TBC_FILL_W-1:0] entries(input logic [2:0] size);
    entries = (size == TBC_SIZE_OFF) ? '0 : (7'h01 << size);
  endfunction

  // Next pointer inside the region that starts at start
  function automatic logic [TBC_PTR_W-1:0] ptr_inc(input logic [TBC_PTR_W-1:0] ptr,
                                                   input logic [TBC_PTR_W-1:0] start,
                                                   input logic [2:0]           size);
    logic [TBC_PTR_W-1:0] mask;
    logic [TBC_PTR_W-1:0] off;
    mask    = 6'(entries(size) - 7'h01);
    off     = ptr - start;
    ptr_inc = start + ((off + 6'h01) & mask);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------

  typedef struct packed {
    tbc_ctrl_s             ctrl;      // Control fields
    logic [TBC_PTR_W-1:0]  start;     // Region start, never read back
    logic [TBC_PTR_W-1:0]  in_ptr;    // Next slot to write
    logic [TBC_PTR_W-1:0]  out_ptr;   // Next slot to drain
    logic [TBC_FILL_W-1:0] fill;      // Words held in memory
    logic                  trig;      // Standard trigger bit
    logic                  transmit_buffer_reg_vld;  // Transmit buffer holds a word
    logic [TBC_DATA_W-1:0] transmit_buffer_reg;      // Transmit buffer word
    logic [31:0]           rdata;     // Read answer
    logic                  std_evt;   // Standard event, one cycle
    logic                  err_evt;   // Error event, one cycle
  } tbc_state_s;

  tbc_state_s            s_r;         // Current state
  tbc_state_s            s_nxt;       // Next state
  logic [TBC_DATA_W-1:0] mem [0:TBC_DEPTH-1];  // Shared entry memory
  logic                  mem_we;      // Store din_data at in_ptr
  logic                  en;          // FIFO mechanism on
  logic                  take;        // Buffer consumed this cycle
  logic                  moved;       // Word moved memory to buffer
  logic                  stored;      // Word written into memory
  logic [TBC_FILL_W-1:0] full_lvl;    // Entry count for current size
  logic                  ctrl_wr;     // Accepted control write
  logic                  stat_wr;     // Status write
  tbc_sreq_s             sreq;        // Router requests

  assign en       = (s_r.ctrl.size != TBC_SIZE_OFF);
  assign take     = transmit_buffer_reg_take && s_r.transmit_buffer_reg_vld;
  assign full_lvl = entries(s_r.ctrl.size);
  assign ctrl_wr  = reg_wr && reg_addr == TBC_OFS_CTRL && tx_buffer_capability;
  assign stat_wr  = reg_wr && reg_addr == TBC_OFS_STATUS;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------

  always_comb begin
    s_nxt         = s_r;
    s_nxt.std_evt = 1'b0;
    s_nxt.err_evt = 1'b0;
    s_nxt.rdata   = '0;
    mem_we        = 1'b0;
    moved         = 1'b0;
    stored        = 1'b0;

    // Drain side: refill the buffer from memory, or leave it empty
    if (take) begin
      if (s_r.fill != '0) begin
        s_nxt.transmit_buffer_reg    = mem[s_r.out_ptr];
        s_nxt.out_ptr = ptr_inc(s_r.out_ptr, s_r.start, s_r.ctrl.size);
        s_nxt.fill    = s_r.fill - 7'h01;
        moved         = 1'b1;
      end else begin
        s_nxt.transmit_buffer_reg_vld = 1'b0;
      end
    end

    // Fill side; with the mechanism off every word is dropped
    if (din_wr && en) begin
      if (!s_nxt.transmit_buffer_reg_vld && s_nxt.fill == '0) begin
        // Straight into the buffer, not counted in the fill level
        s_nxt.transmit_buffer_reg     = din_data;
        s_nxt.transmit_buffer_reg_vld = 1'b1;
      end else if (s_nxt.fill >= full_lvl) begin
        // Word lost; only flagged
        s_nxt.err_evt = 1'b1;
      end else begin
        mem_we       = 1'b1;
        stored       = 1'b1;
        s_nxt.in_ptr = ptr_inc(s_r.in_ptr, s_r.start, s_r.ctrl.size);
        s_nxt.fill   = s_nxt.fill + 7'h01;
      end
    end

    // Limit crossing and trigger bit events; old level is compared
    if (s_r.ctrl.limit_overflow_select) begin
      s_nxt.std_evt = stored && s_r.fill == {1'b0, s_r.ctrl.limit};
    end else begin
      s_nxt.std_evt = moved && s_r.fill == {1'b0, s_r.ctrl.limit};
    end
    if (s_r.trig && s_r.ctrl.trig_en && (s_r.ctrl.limit_overflow_select ? stored : moved)) begin
      s_nxt.std_evt = 1'b1;
    end

    // Trigger clears on reaching its target level
    if (s_r.trig) begin
      if (s_r.ctrl.trig_mode) begin
        if (s_nxt.fill == full_lvl) begin
          s_nxt.trig = 1'b0;
        end
      end else if (s_nxt.fill == {1'b0, s_r.ctrl.limit}) begin
        s_nxt.trig = 1'b0;
      end
    end

    // Status writes; a software set wins over the hardware clear
    if (stat_wr) begin
      if (reg_wdata[TBC_S_FLUSH]) begin
        s_nxt.out_ptr = s_nxt.in_ptr;
        s_nxt.fill    = '0;
      end
      if (reg_wdata[TBC_S_TRIG]) begin
        s_nxt.trig = 1'b1;
      end
    end

    // Control write; pointers follow only while the size is zero
    if (ctrl_wr) begin
      s_nxt.ctrl.limit     = reg_wdata[TBC_F_LIMIT_LO +: 6];
      s_nxt.ctrl.trig_mode = reg_wdata[TBC_F_TMODE];
      s_nxt.ctrl.trig_en   = reg_wdata[TBC_F_TEN];
      s_nxt.ctrl.std_node  = reg_wdata[TBC_F_SNODE_LO +: 3];
      s_nxt.ctrl.alt_node  = reg_wdata[TBC_F_ANODE_LO +: 3];
      s_nxt.ctrl.size      = reg_wdata[TBC_F_SIZE_LO +: 3];
      s_nxt.ctrl.limit_overflow_select       = reg_wdata[TBC_F_LOF];
      s_nxt.ctrl.std_ien   = reg_wdata[TBC_F_SIEN];
      s_nxt.ctrl.err_ien   = reg_wdata[TBC_F_EIEN];
      if (!en) begin
        s_nxt.start   = reg_wdata[TBC_F_FIFO_START_POINTER_LO +: TBC_PTR_W];
        s_nxt.in_ptr  = reg_wdata[TBC_F_FIFO_START_POINTER_LO +: TBC_PTR_W];
        s_nxt.out_ptr = reg_wdata[TBC_F_FIFO_START_POINTER_LO +: TBC_PTR_W];
        s_nxt.fill    = '0;
      end
      // Nonzero size: start and pointers keep their values
    end

    // Read answer, valid in the next cycle only
    if (reg_rd) begin
      case (reg_addr)
        TBC_OFS_CTRL: begin
          // Start pointer and reserved bits stay zero
          s_nxt.rdata[TBC_F_LIMIT_LO +: 6]  = s_r.ctrl.limit;
          s_nxt.rdata[TBC_F_TMODE]          = s_r.ctrl.trig_mode;
          s_nxt.rdata[TBC_F_TEN]            = s_r.ctrl.trig_en;
          s_nxt.rdata[TBC_F_SNODE_LO +: 3]  = s_r.ctrl.std_node;
          s_nxt.rdata[TBC_F_ANODE_LO +: 3]  = s_r.ctrl.alt_node;
          s_nxt.rdata[TBC_F_SIZE_LO +: 3]   = s_r.ctrl.size;
          s_nxt.rdata[TBC_F_LOF]            = s_r.ctrl.limit_overflow_select;
          s_nxt.rdata[TBC_F_SIEN]           = s_r.ctrl.std_ien;
          s_nxt.rdata[TBC_F_EIEN]           = s_r.ctrl.err_ien;
        end
        TBC_OFS_STATUS: begin
          s_nxt.rdata[TBC_S_TRIG]                 = s_r.trig;
          s_nxt.rdata[TBC_S_FLUSH]                = s_r.transmit_buffer_reg_vld;
          s_nxt.rdata[TBC_S_FILL_LO +: TBC_FILL_W] = s_r.fill;
          s_nxt.rdata[TBC_S_INP_LO +: TBC_PTR_W]  = s_r.in_ptr;
          s_nxt.rdata[TBC_S_OUTP_LO +: TBC_PTR_W] = s_r.out_ptr;
        end
        default: begin
          // Unmapped offsets read zero
          s_nxt.rdata = '0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State and memory registers
  // ---------------------------------------------------------------

  // All state resets, the transmit buffer word included
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Memory has no reset: its words are only read behind a nonzero fill
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[s_r.in_ptr] <= din_data;
    end
  end

  // ---------------------------------------------------------------
  // Service requests
  // ---------------------------------------------------------------

  // Trigger level keeps the standard output up until the bit clears
  always_comb begin
    sreq.std_pulse = s_r.std_evt && s_r.ctrl.std_ien;
    sreq.std_level = s_r.trig && s_r.ctrl.trig_en && s_r.ctrl.std_ien;
    sreq.std_node  = s_r.ctrl.std_node;
    sreq.err_pulse = s_r.err_evt && s_r.ctrl.err_ien;
    sreq.err_node  = s_r.ctrl.alt_node;
  end

  tbc_sr_router u_router (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sreq    (sreq),
    .sr_out  (sr_out)
  );

  assign reg_rdata  = s_r.rdata;
  assign transmit_buffer_reg_valid = s_r.transmit_buffer_reg_vld;
  assign transmit_buffer_reg_data  = s_r.transmit_buffer_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------

  a_fifo_start_pointer_reads_zero: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == TBC_OFS_CTRL |=> reg_rdata[5:0] == 6'h00)
    else $error("start pointer read back nonzero");

  a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == TBC_OFS_CTRL |=>
      reg_rdata[7:6] == 2'h0 && reg_rdata[23:22] == 2'h0 && !reg_rdata[27] && !reg_rdata[29])
    else $error("reserved control bits read nonzero");

  a_fifo_start_pointer_loads_ptrs: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_wr && !en |=> s_r.in_ptr == $past(reg_wdata[5:0]) &&
      s_r.out_ptr == $past(reg_wdata[5:0]) && s_r.fill == 7'h00)
    else $error("start write at size zero did not load pointers");

  a_fifo_start_pointer_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_wr && en && !din_wr && !transmit_buffer_reg_take && !stat_wr |=>
      $stable(s_r.in_ptr) && $stable(s_r.out_ptr) && $stable(s_r.start))
    else $error("start write at nonzero size moved pointers");

  a_cap_blocks: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == TBC_OFS_CTRL && !tx_buffer_capability |=> $stable(s_r.ctrl))
    else $error("control changed without capability");

  a_disabled_refuse: assert property (@(posedge clk) disable iff (sys_rst)
    !en && din_wr && !transmit_buffer_reg_take && !reg_wr |=> $stable(s_r.transmit_buffer_reg_vld) && $stable(s_r.transmit_buffer_reg))
    else $error("disabled FIFO accepted data");

  a_first_bypass: assert property (@(posedge clk) disable iff (sys_rst)
    en && din_wr && !s_r.transmit_buffer_reg_vld && s_r.fill == 7'h00 && !reg_wr |=>
      transmit_buffer_reg_valid && s_r.fill == 7'h00 && transmit_buffer_reg_data == $past(din_data))
    else $error("first word did not bypass into buffer");

  a_err_on_full: assert property (@(posedge clk) disable iff (sys_rst)
    en && din_wr && s_r.transmit_buffer_reg_vld && s_r.fill == full_lvl && !transmit_buffer_reg_take |=>
      s_r.err_evt ##1 sr_out[$past(s_r.ctrl.alt_node)] || !$past(s_r.ctrl.err_ien) ||
      $past(s_r.ctrl.alt_node) > 3'h5)
    else $error("write to full FIFO not flagged");

  a_lof_low: assert property (@(posedge clk) disable iff (sys_rst)
    !s_r.ctrl.limit_overflow_select && take && s_r.fill != 7'h00 && s_r.fill == {1'b0, s_r.ctrl.limit}
      |=> s_r.std_evt)
    else $error("drop from limit raised no event");

  a_lof_high: assert property (@(posedge clk) disable iff (sys_rst)
    s_r.ctrl.limit_overflow_select && stored && s_r.fill == {1'b0, s_r.ctrl.limit} |=> s_r.std_evt)
    else $error("rise from limit raised no event");

  a_trig_level: assert property (@(posedge clk) disable iff (sys_rst)
    s_r.trig && s_r.ctrl.trig_en && s_r.ctrl.std_ien && s_r.ctrl.std_node <= 3'h5
      |=> sr_out[$past(s_r.ctrl.std_node)])
    else $error("trigger bit did not hold request output");

  a_ptr_wraps: assert property (@(posedge clk) disable iff (sys_rst)
    mem_we && !reg_wr |=> s_r.in_ptr == ptr_inc($past(s_r.in_ptr), s_r.start, s_r.ctrl.size))
    else $error("input pointer did not wrap in region");

endmodule

`default_nettype wire

/* File: hdl/tbc_pkg.sv */
/*
  Shared constants and types of the transmit FIFO buffer control block.
  Assumes a single 100 MHz clock domain and a byte-addressed register port.
*/
`default_nettype none

package tbc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int          TBC_ADDR_W      = 8;
  localparam logic [7:0]  TBC_OFS_CTRL    = 8'h00;   // Control word
  localparam logic [7:0]  TBC_OFS_STATUS  = 8'h04;   // Fill state, trigger, pointers
  localparam logic [31:0] TBC_CTRL_RESET  = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Control field positions
  // ---------------------------------------------------------------
  localparam int TBC_F_FIFO_START_POINTER_LO   = 0;    // Start pointer [5:0], write-only
  localparam int TBC_F_LIMIT_LO  = 8;    // Limit [13:8]
  localparam int TBC_F_TMODE     = 14;   // Trigger mode
  localparam int TBC_F_TEN       = 15;   // Trigger enable
  localparam int TBC_F_SNODE_LO  = 16;   // Standard node [18:16]
  localparam int TBC_F_ANODE_LO  = 19;   // Error node [21:19]
  localparam int TBC_F_SIZE_LO   = 24;   // Size code [26:24]
  localparam int TBC_F_LOF       = 28;   // Limit overflow select
  localparam int TBC_F_SIEN      = 30;   // Standard interrupt enable
  localparam int TBC_F_EIEN      = 31;   // Error interrupt enable

  // ---------------------------------------------------------------
  // Status field positions
  // ---------------------------------------------------------------
  localparam int TBC_S_TRIG      = 0;    // Trigger bit; write 1 sets it
  localparam int TBC_S_FLUSH     = 1;    // Write 1 flushes; reads buffer-valid
  localparam int TBC_S_FILL_LO   = 8;    // Fill level [14:8]
  localparam int TBC_S_INP_LO    = 16;   // Input pointer [21:16]
  localparam int TBC_S_OUTP_LO   = 24;   // Output pointer [29:24]

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int          TBC_PTR_W    = 6;
  localparam int          TBC_FILL_W   = 7;
  localparam int          TBC_DEPTH    = 64;     // Shared entry memory
  localparam int          TBC_DATA_W   = 32;
  localparam int          TBC_NODES    = 6;      // Service request outputs
  localparam logic [2:0]  TBC_SIZE_OFF = 3'h0;   // FIFO disabled

  // Stored control fields
  typedef struct packed {
    logic                  err_ien;
    logic                  std_ien;
    logic                  limit_overflow_select;
    logic [2:0]            size;
    logic [2:0]            alt_node;
    logic [2:0]            std_node;
    logic                  trig_en;
    logic                  trig_mode;
    logic [5:0]            limit;
  } tbc_ctrl_s;

  // Event requests handed to the service request router
  typedef struct packed {
    logic                  std_pulse;
    logic                  std_level;
    logic [2:0]            std_node;
    logic                  err_pulse;
    logic [2:0]            err_node;
  } tbc_sreq_s;

endpackage

`default_nettype wire

/* File: hdl/tbc_sr_router.sv */
/*
  Service request router: steers the standard and error requests onto one
  of six outputs. Assumes requests come from logic on the same clock.
*/
`default_nettype none

module tbc_sr_router
  import tbc_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Requests
  input  wire tbc_sreq_s            sreq,
  // Service request outputs
  output var  logic [TBC_NODES-1:0] sr_out
);

  // ---------------------------------------------------------------
  // Routing
  // ---------------------------------------------------------------

  logic [TBC_NODES-1:0] sr_r;    // Registered outputs
  logic [TBC_NODES-1:0] sr_nxt;  // Next outputs

  // One output per node; reserved codes match no node and stay silent
  genvar g;
  generate
    for (g = 0; g < TBC_NODES; g++) begin : g_node
      always_comb begin
        sr_nxt[g] = ((sreq.std_pulse | sreq.std_level) && sreq.std_node == 3'(g)) ||
                    (sreq.err_pulse && sreq.err_node == 3'(g));
      end
    end
  endgenerate

  // Output register, so the pins never glitch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sr_r <= '0;
    end else begin
      sr_r <= sr_nxt;
    end
  end

  assign sr_out = sr_r;

endmodule

`default_nettype wire

/* File: testbench/tbc_chan_model.sv */
/*
  Channel side model: consumes the transmit buffer word by word.
  Assumes the bench drives stall and slow on the same clock.
*/
`default_nettype none

module tbc_chan_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Pacing from the bench
  input  wire logic stall,
  input  wire logic slow,
  // Transmit buffer
  input  wire logic transmit_buffer_reg_valid,
  output var  logic transmit_buffer_reg_take
);
  timeunit 1ns;
  timeprecision 1ps;

  // Take when a word is offered; slow mode leaves a gap after each take
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      transmit_buffer_reg_take <= 1'b0;
    end else begin
      transmit_buffer_reg_take <= transmit_buffer_reg_valid & ~stall & ~(slow & transmit_buffer_reg_take);
    end
  end
endmodule

`default_nettype wire

/* File: testbench/tb.sv */
/*
  Self-checking bench of the transmit FIFO control block.
  Assumes the channel model in tbc_chan_model.sv.
*/
`default_nettype none

module tb import tbc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, cap = 1;
  logic        din_wr = 0, stall = 1, slow = 0, transmit_buffer_reg_take, transmit_buffer_reg_valid;
  logic [7:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, din_data = 0, reg_rdata, transmit_buffer_reg_data, rv, d;
  logic [5:0]  sr_out;
  logic [31:0] q[$];
  int          seed = 78, n_errors = 0, num_checks = 0, e, st;
  int          sr_cnt[6] = '{default: 0};

  always #5 clk = ~clk;

  tbc_fifo_ctrl dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_buffer_capability(cap), .din_wr(din_wr), .din_data(din_data),
    .transmit_buffer_reg_take(transmit_buffer_reg_take), .transmit_buffer_reg_valid(transmit_buffer_reg_valid), .transmit_buffer_reg_data(transmit_buffer_reg_data),
    .sr_out(sr_out));

  tbc_chan_model chan_u (.clk(clk), .sys_rst(sys_rst), .stall(stall), .slow(slow),
    .transmit_buffer_reg_valid(transmit_buffer_reg_valid), .transmit_buffer_reg_take(transmit_buffer_reg_take));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Control word: size, limit, standard node, error node
  function automatic logic [31:0] cw(input int sz, lm, sn, an);
    return (sz << 24) | (lm << 8) | (sn << 16) | (an << 19);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_wr    <= 1;
    @(posedge clk);
    reg_wr    <= 0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1;
    @(posedge clk);
    reg_rd   <= 0;
    @(negedge clk);
    rv = reg_rdata;
  endtask

  // Size zero first, so the start pointer in c always loads
  task automatic cfg(input logic [31:0] c);
    wr(8'h00, 0);
    wr(8'h00, c);
  endtask

  task automatic push(input bit keep);
    d = $random(seed);
    @(posedge clk);
    din_wr   <= 1;
    din_data <= d;
    @(posedge clk);
    din_wr   <= 0;
    if (keep) q.push_back(d);
  endtask

  // Release the channel and wait, bounded, until the buffer is empty
  task automatic drain();
    @(posedge clk);
    stall <= 0;
    slow  <= 1'($random(seed));
    for (int i = 0; i <= 300 && transmit_buffer_reg_valid !== 1'b0; i++) begin
      if (i == 300) begin
        n_errors++;
        complete_run();
      end
      @(negedge clk);
    end
    @(posedge clk);
    stall <= 1;
  endtask

  // ------------------------------------------------------------
  // Monitors: word order at the buffer, service request counts
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!sys_rst && transmit_buffer_reg_take && transmit_buffer_reg_valid && q.size() > 0)
      chk(transmit_buffer_reg_data, q.pop_front());
    for (int i = 0; i < 6; i++) sr_cnt[i] += sr_out[i];
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 0;
    cap <= 0;
    wr(8'h00, 32'h0100_0000);
    cap <= 1;
    rd(8'h00);
    chk(rv, 0);
    // Every bit written as one except reserved 23:22, 27 and 29; reserved 7:6 still read back zero
    wr(8'h00, 32'hd73f_ffff);
    rd(8'h00);
    chk(rv, 32'hd73f_ff00);
    rd(8'h10);
    chk(rv, 0);
    // Disabled buffer drops data
    cfg(32'h8000_0000);
    push(0);
    rd(8'h04);
    chk(rv, 0);
    // Size codes 1 to 6: fill, overflow error, drain
    for (int s = 1; s <= 6; s++) begin
      st = $random(seed) & 63;
      cfg(cw(s, 0, 0, s - 1) | 32'h8000_0000 | st);
      wr(8'h00, cw(s, 0, 0, s - 1) | 32'h8000_0000 | (st ^ 1));
      for (int i = 0; i <= (1 << s); i++) push(1);
      rd(8'h04);
      chk(rv & 32'h3f3f_7f02, (st << 24) | (st << 16) | (1 << (s + 8)) | 2);
      @(negedge clk) e = sr_cnt[s - 1];
      push(0);
      repeat (3) @(posedge clk);
      @(negedge clk) chk(sr_cnt[s - 1] - e, 1);
      if (s == 6) begin
        // Error enable off: a write to the full buffer stays silent
        wr(8'h00, cw(s, 0, 0, s - 1));
        @(negedge clk) e = sr_cnt[s - 1];
        push(0);
        repeat (3) @(posedge clk);
        @(negedge clk) chk(sr_cnt[s - 1] - e, 0);
      end
      drain();
      rd(8'h04);
      chk(rv & 32'h3f3f_7f03, (st << 24) | (st << 16));
    end
    // Limit events on every standard node, both directions, one disabled
    for (int k = 0; k <= 6; k++) begin
      cfg(cw(3, 2, k % 6, 0) | ((k < 6) << 30) | ((k & 1) << 28));
      @(negedge clk) e = sr_cnt[k % 6];
      repeat (5) push(1);
      drain();
      repeat (3) @(posedge clk);
      @(negedge clk) chk(sr_cnt[k % 6] - e, k < 6);
    end
    // Flush drops the stored word and keeps the buffer word
    cfg(cw(1, 0, 0, 0));
    push(1);
    push(0);
    wr(8'h04, 2);
    rd(8'h04);
    chk(rv & 32'h3f3f_7f03, 32'h0101_0002);
    drain();
    // Trigger bit in both modes, gated and ungated
    for (int m = 0; m < 4; m++) begin
      cfg(cw(2, 3, 1, 0) | 32'h4000_0000 | ((m & 1) << 14) | ((m >> 1) << 15));
      wr(8'h04, 1);
      repeat (3) @(posedge clk);
      @(negedge clk) chk(sr_out[1], m >> 1);
      repeat (4) push(1);
      rd(8'h04);
      chk(rv[0], m & 1);
      push(1);
      rd(8'h04);
      chk(rv[0], 0);
      drain();
    end
    // Every kept word must have reached the channel
    chk(q.size(), 0);
    complete_run();
  end
endmodule

`default_nettype wire
